/* File: bts_sequencer.sv */
`timescale 1ns/1ns
// Function
// - Execute only when condition field passes
// - List bit n selects register n
// - Stored program counter is instruction plus 8
// - Lowest register at lowest address, ordered
// - Transfers run in ascending register order
// - Addresses from base, pre/post and up/down
// - No write-back keeps base unless loaded
// - Unaligned base: no rotate, low bits driven
// - Load pc with special bit restores status
// - Store with special bit reads user bank
// - Load without pc, special bit: user bank
// - Pc low two bits read zero, ignored
// - Abort stops transfers and restores base
// - Stored base is original value
module bts_sequencer (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Register file read port
  output logic      [3:0]  rf_rd_idx,
  output logic             rf_rd_user,
  input  wire logic [31:0] rf_rd_data,
  // Register file write port
  output logic             rf_we,
  output logic      [3:0]  rf_wr_idx,
  output logic             rf_wr_user,
  output logic      [31:0] rf_wr_data,
  output logic             status_restore,
  // Memory port
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic        mem_abort
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Flags are {N, Z, C, V}
  function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cy, v;
    n = f[3];
    z = f[2];
    cy = f[1];
    v = f[0];
    case (c)
      4'h0: cond_pass = z;
      4'h1: cond_pass = !z;
      4'h2: cond_pass = cy;
      4'h3: cond_pass = !cy;
      4'h4: cond_pass = n;
      4'h5: cond_pass = !n;
      4'h6: cond_pass = v;
      4'h7: cond_pass = !v;
      4'h8: cond_pass = cy && !z;
      4'h9: cond_pass = !cy || z;
      4'ha: cond_pass = n == v;
      4'hb: cond_pass = n != v;
      4'hc: cond_pass = !z && (n == v);
      4'hd: cond_pass = z || (n != v);
      4'he: cond_pass = 1'b1;
      default: cond_pass = 1'b0; // Never code
    endcase
  endfunction

  // Selected register count
  function automatic logic [4:0] pop16(input logic [15:0] l);
    pop16 = 5'h00;
    for (int i = 0; i < 16; i++) begin
      pop16 = pop16 + {4'h0, l[i]};
    end
  endfunction

  // Lowest selected register
  function automatic logic [3:0] low_idx(input logic [15:0] l);
    low_idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (l[i]) begin
        low_idx = 4'(i);
      end
    end
  endfunction

  // Byte span of n words
  function automatic logic [31:0] span(input logic [4:0] n);
    span = {25'h0000000, n, 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  bts_pkg::bts_state_t st_q;            // Sequencer state
  logic [31:0] instr_q;                 // Instruction word
  logic [31:0] pc_q;                    // Instruction address
  logic [3:0]  flags_q;                 // Condition flags
  logic [31:0] base_q;                  // Base before the instruction
  logic [31:0] addr_q;                  // Next transfer address
  logic [31:0] final_q;                 // Modified base
  logic [15:0] pend_q;                  // Registers still to move
  logic [3:0]  idx_q;                   // Register in flight
  logic        done_q, abrt_q, skip_q;  // Sticky status
  logic [31:0] prdata_q;
  logic        mem_req_q, mem_we_q;
  logic [31:0] mem_addr_q, mem_wdata_q;
  logic        rf_we_q, rf_wr_user_q, restore_q;
  logic [3:0]  rf_wr_idx_q;
  logic [31:0] rf_wr_data_q;

  logic        is_load, s_bit, wb_bit, p_bit, u_bit, pc_listed;
  logic [3:0]  base_idx;
  logic [15:0] list;
  logic        wr_acc, rd_setup, go, pass;
  logic [4:0]  n_sel;

  assign list      = instr_q[bts_pkg::LIST_HI:0];
  assign is_load   = instr_q[bts_pkg::L_BIT];
  assign s_bit     = instr_q[bts_pkg::S_BIT];
  assign wb_bit    = instr_q[bts_pkg::W_BIT];
  assign p_bit     = instr_q[bts_pkg::P_BIT];
  assign u_bit     = instr_q[bts_pkg::U_BIT];
  assign base_idx  = instr_q[bts_pkg::BASE_HI:bts_pkg::BASE_LO];
  assign pc_listed = list[bts_pkg::PC_IDX];
  assign n_sel     = pop16(list);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1; // Always ready, no wait states
  assign pass     = cond_pass(instr_q[bts_pkg::COND_HI:bts_pkg::COND_LO], flags_q);
  // Start only honoured when idle
  assign go = wr_acc && (paddr == bts_pkg::ADDR_CTRL) && pwdata[bts_pkg::START_BIT] &&
              (st_q == bts_pkg::BTS_IDLE);

  // Unmapped addresses answer with an error
  always_comb begin
    if (paddr == bts_pkg::ADDR_INSTR || paddr == bts_pkg::ADDR_PC ||
        paddr == bts_pkg::ADDR_FLAGS || paddr == bts_pkg::ADDR_CTRL ||
        paddr == bts_pkg::ADDR_RESULT) begin
      pslverr = 1'b0;
    end else begin
      pslverr = psel && penable;
    end
  end

  // Software registers; the instruction is frozen while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q <= bts_pkg::RST_WORD;
      pc_q    <= bts_pkg::RST_WORD;
      flags_q <= bts_pkg::RST_FLAGS;
    end else if (wr_acc && st_q == bts_pkg::BTS_IDLE) begin
      if (paddr == bts_pkg::ADDR_INSTR) begin
        instr_q <= pwdata;
      end else if (paddr == bts_pkg::ADDR_PC) begin
        pc_q <= pwdata;
      end else if (paddr == bts_pkg::ADDR_FLAGS) begin
        flags_q <= pwdata[3:0];
      end
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= bts_pkg::RST_WORD;
    end else if (rd_setup) begin
      if (paddr == bts_pkg::ADDR_INSTR) begin
        prdata_q <= instr_q;
      end else if (paddr == bts_pkg::ADDR_PC) begin
        prdata_q <= pc_q;
      end else if (paddr == bts_pkg::ADDR_FLAGS) begin
        prdata_q <= {28'h0000000, flags_q};
      end else if (paddr == bts_pkg::ADDR_CTRL) begin
        prdata_q <= {28'h0000000, skip_q, abrt_q, done_q, st_q != bts_pkg::BTS_IDLE};
      end else if (paddr == bts_pkg::ADDR_RESULT) begin
        prdata_q <= final_q;
      end else begin
        prdata_q <= bts_pkg::RST_WORD;
      end
    end
  end
  assign prdata = prdata_q;

  // Sticky status; the next start clears done and abort and sets skip on a failed condition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      abrt_q <= 1'b0;
      skip_q <= 1'b0;
    end else if (go) begin
      done_q <= 1'b0;
      abrt_q <= 1'b0;
      skip_q <= !pass;
    end else begin
      done_q <= done_q || st_q == bts_pkg::BTS_FIN || st_q == bts_pkg::BTS_ABORT;
      abrt_q <= abrt_q || st_q == bts_pkg::BTS_ABORT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= bts_pkg::BTS_IDLE;
    end else begin
      case (st_q)
        bts_pkg::BTS_IDLE:  st_q <= (go && pass) ? bts_pkg::BTS_BASE : bts_pkg::BTS_IDLE;
        bts_pkg::BTS_BASE:  st_q <= (list == 16'h0000) ? bts_pkg::BTS_FIN : bts_pkg::BTS_ISSUE;
        bts_pkg::BTS_ISSUE: st_q <= bts_pkg::BTS_WAIT;
        bts_pkg::BTS_WAIT: begin
          if (mem_abort) begin
            st_q <= bts_pkg::BTS_ABORT;
          end else if (mem_ack) begin
            st_q <= (pend_q == 16'h0000) ? bts_pkg::BTS_FIN : bts_pkg::BTS_ISSUE;
          end
        end
        default: st_q <= bts_pkg::BTS_IDLE;
      endcase
    end
  end

  // Addressing: capture base, lowest address and final base
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_q  <= bts_pkg::RST_WORD;
      addr_q  <= bts_pkg::RST_WORD;
      final_q <= bts_pkg::RST_WORD;
    end else if (st_q == bts_pkg::BTS_BASE) begin
      base_q <= rf_rd_data;
      // Low bits of an unaligned base pass straight through
      if (u_bit) begin
        addr_q  <= p_bit ? rf_rd_data + bts_pkg::WORD_STEP : rf_rd_data;
        final_q <= rf_rd_data + span(n_sel);
      end else begin
        addr_q  <= p_bit ? rf_rd_data - span(n_sel) :
                   rf_rd_data - span(n_sel) + bts_pkg::WORD_STEP;
        final_q <= rf_rd_data - span(n_sel);
      end
    end else if (st_q == bts_pkg::BTS_WAIT && mem_ack && !mem_abort) begin
      addr_q <= addr_q + bts_pkg::WORD_STEP;
    end
  end

  // Pending list; lowest bit first keeps order ascending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 16'h0000;
      idx_q  <= 4'h0;
    end else if (st_q == bts_pkg::BTS_BASE) begin
      pend_q <= list;
    end else if (st_q == bts_pkg::BTS_ISSUE) begin
      idx_q  <= low_idx(pend_q);
      pend_q <= pend_q & ~(16'h0001 << low_idx(pend_q));
    end
  end

  // Register read port: base from current bank, stores per bank rule
  always_comb begin
    if (st_q == bts_pkg::BTS_ISSUE) begin
      rf_rd_idx  = low_idx(pend_q);
      rf_rd_user = s_bit && !is_load;
    end else begin
      rf_rd_idx  = base_idx; // Base index as decoded
      rf_rd_user = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory request; held until ack or abort
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req_q   <= 1'b0;
      mem_we_q    <= 1'b0;
      mem_addr_q  <= bts_pkg::RST_WORD;
      mem_wdata_q <= bts_pkg::RST_WORD;
    end else if (st_q == bts_pkg::BTS_ISSUE) begin
      mem_req_q  <= 1'b1;
      mem_we_q   <= !is_load;
      mem_addr_q <= addr_q;
      // Base reads its original value since write-back comes last
      mem_wdata_q <= (low_idx(pend_q) == bts_pkg::PC_IDX) ?
                     ((pc_q + bts_pkg::PC_AHEAD) & bts_pkg::PC_MASK) : rf_rd_data;
    end else if (st_q == bts_pkg::BTS_WAIT && (mem_ack || mem_abort)) begin
      mem_req_q <= 1'b0;
    end
  end
  assign mem_req   = mem_req_q;
  assign mem_we    = mem_we_q;
  assign mem_addr  = mem_addr_q;
  assign mem_wdata = mem_wdata_q;

  // Register writes: loaded words, abort restore, write-back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_we_q      <= 1'b0;
      rf_wr_idx_q  <= 4'h0;
      rf_wr_user_q <= 1'b0;
      rf_wr_data_q <= bts_pkg::RST_WORD;
      restore_q    <= 1'b0;
    end else begin
      rf_we_q   <= 1'b0;
      restore_q <= 1'b0;
      if (st_q == bts_pkg::BTS_WAIT && mem_ack && !mem_abort && is_load) begin
        rf_we_q      <= 1'b1;
        rf_wr_idx_q  <= idx_q;
        rf_wr_user_q <= s_bit && !pc_listed;
        rf_wr_data_q <= (idx_q == bts_pkg::PC_IDX) ?
                        (mem_rdata & bts_pkg::PC_MASK) : mem_rdata;
        restore_q    <= s_bit && idx_q == bts_pkg::PC_IDX;
      end else if (st_q == bts_pkg::BTS_ABORT) begin
        rf_we_q      <= 1'b1;
        rf_wr_idx_q  <= base_idx;
        rf_wr_user_q <= 1'b0;
        rf_wr_data_q <= base_q;
      end else if (st_q == bts_pkg::BTS_FIN && wb_bit) begin
        rf_we_q      <= 1'b1;
        rf_wr_idx_q  <= base_idx;
        rf_wr_user_q <= 1'b0;
        rf_wr_data_q <= final_q; // Without it base stays or keeps loaded word
      end
    end
  end
  assign rf_we          = rf_we_q;
  assign rf_wr_idx      = rf_wr_idx_q;
  assign rf_wr_user     = rf_wr_user_q;
  assign rf_wr_data     = rf_wr_data_q;
  assign status_restore = restore_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_abort_seen;
    st_q == bts_pkg::BTS_WAIT && mem_abort;
  endsequence
  sequence s_base_back;
    rf_we_q && rf_wr_idx_q == base_idx && rf_wr_data_q == base_q;
  endsequence

  a_cond_fail_idle: assert property (go && !pass |=> st_q == bts_pkg::BTS_IDLE [*3])
    else $error("failed condition started a transfer");
  a_pc_store_val: assert property (mem_req_q && mem_we_q && idx_q == bts_pkg::PC_IDX
    |-> mem_wdata_q == ((pc_q + bts_pkg::PC_AHEAD) & bts_pkg::PC_MASK))
    else $error("stored pc value wrong");
  a_addr_step_up: assert property (st_q == bts_pkg::BTS_WAIT && mem_ack && !mem_abort &&
    pend_q != 16'h0000 |-> ##2 mem_addr_q == $past(mem_addr_q, 2) + bts_pkg::WORD_STEP)
    else $error("address did not step by one word");
  a_order_ascend: assert property (st_q == bts_pkg::BTS_WAIT
    |-> (pend_q & ((16'h0001 << idx_q) - 16'h0001)) == 16'h0000)
    else $error("lower register left pending");
  a_first_addr: assert property (st_q == bts_pkg::BTS_BASE && list != 16'h0000 |-> ##2
    mem_addr_q == (u_bit ? (p_bit ? base_q + bts_pkg::WORD_STEP : base_q) :
    (p_bit ? base_q - span(n_sel) : base_q - span(n_sel) + bts_pkg::WORD_STEP)))
    else $error("first address wrong");
  a_no_wb_base: assert property (st_q == bts_pkg::BTS_FIN && !wb_bit |=> !rf_we_q)
    else $error("base written without write-back");
  a_low_bits: assert property (mem_req_q |-> mem_addr_q[1:0] == base_q[1:0])
    else $error("address low bits altered");
  a_status_copy: assert property (rf_we_q && rf_wr_idx_q == bts_pkg::PC_IDX && is_load
    && s_bit && st_q != bts_pkg::BTS_IDLE |-> status_restore)
    else $error("status not restored with pc load");
  a_user_store: assert property (st_q == bts_pkg::BTS_ISSUE && !is_load |-> rf_rd_user == s_bit)
    else $error("store bank selection wrong");
  a_user_load: assert property (rf_we_q && is_load && s_bit && !pc_listed &&
    $past(st_q) == bts_pkg::BTS_WAIT |-> rf_wr_user)
    else $error("user bank load missed");
  a_pc_low_zero: assert property (rf_we_q && rf_wr_idx_q == bts_pkg::PC_IDX
    |-> rf_wr_data_q[1:0] == 2'b00)
    else $error("pc low bits not cleared");
  a_abort_restore: assert property (s_abort_seen |=> ##1 s_base_back)
    else $error("base not restored after abort");
  a_wb_final: assert property (st_q == bts_pkg::BTS_FIN && wb_bit
    |=> rf_we_q && rf_wr_data_q == final_q)
    else $error("write-back value wrong");

endmodule

/* File: bts_pkg.sv */
package bts_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the APB port
  localparam logic [7:0]  ADDR_INSTR  = 8'h00; // Instruction word
  localparam logic [7:0]  ADDR_PC     = 8'h04; // Address of the instruction
  localparam logic [7:0]  ADDR_FLAGS  = 8'h08; // Condition flags N Z C V
  localparam logic [7:0]  ADDR_CTRL   = 8'h0c; // Write start, read status
  localparam logic [7:0]  ADDR_RESULT = 8'h10; // Final base address
  ////////////////////////////////////////////////////////////////////////////
  // Instruction field positions
  localparam int COND_HI = 31;
  localparam int COND_LO = 28;
  localparam int P_BIT   = 24;
  localparam int U_BIT   = 23;
  localparam int S_BIT   = 22;
  localparam int W_BIT   = 21;
  localparam int L_BIT   = 20;
  localparam int BASE_HI = 19;
  localparam int BASE_LO = 16;
  localparam int LIST_HI = 15;
  ////////////////////////////////////////////////////////////////////////////
  // Control and status bit positions
  localparam int START_BIT = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ABRT = 2;
  localparam int STAT_SKIP = 3;
  ////////////////////////////////////////////////////////////////////////////
  // Constants and reset values
  localparam logic [3:0]  PC_IDX    = 4'hf;          // Program counter index
  localparam logic [31:0] PC_AHEAD  = 32'h00000008;  // Stored pc lead
  localparam logic [31:0] WORD_STEP = 32'h00000004;  // One word
  localparam logic [31:0] PC_MASK   = 32'hfffffffc;  // Low two bits forced zero
  localparam logic [31:0] RST_WORD  = 32'h00000000;
  localparam logic [3:0]  RST_FLAGS = 4'h0;
  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    BTS_IDLE  = 6'h01,
    BTS_BASE  = 6'h02,
    BTS_ISSUE = 6'h04,
    BTS_WAIT  = 6'h08,
    BTS_ABORT = 6'h10,
    BTS_FIN   = 6'h20
  } bts_state_t;
endpackage

/* File: bts_mem_model.sv */
`timescale 1ns/1ns
module bts_mem_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Request from the sequencer
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  // Answer to the sequencer
  output logic      [31:0] mem_rdata,
  output logic             mem_ack,
  output logic             mem_abort,
  // Behaviour chosen by the bench
  input  wire logic [7:0]  wait_cyc,
  input  wire logic [31:0] abort_addr
);
  ////////////////////////////////////////////////////////////
  logic [31:0] mem_q [1024]; // Word store, address bits 11:2
  logic [7:0]  cnt_q;        // Wait cycles spent on this request
  logic [31:0] junk_q;       // Filler, moves every cycle

  // Data only while answering, so a stale word never passes
  assign mem_rdata = mem_ack ? mem_q[mem_addr[11:2]] : junk_q;

  // Free-running filler pattern
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      junk_q <= 32'h3c3c3c3c;
    end else begin
      junk_q <= ~junk_q + 32'h01010101;
    end
  end

  // Answer after the set wait; one chosen address aborts instead
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= 8'h00;
      mem_ack   <= 1'b0;
      mem_abort <= 1'b0;
    end else if (mem_ack || mem_abort) begin
      // Answer lasts one cycle
      cnt_q     <= 8'h00;
      mem_ack   <= 1'b0;
      mem_abort <= 1'b0;
    end else if (mem_req && cnt_q == wait_cyc) begin
      mem_abort <= (mem_addr == abort_addr);
      mem_ack   <= (mem_addr != abort_addr);
    end else if (mem_req) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // Store at the acknowledging edge; reset refills a known pattern
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 1024; i++) begin
        mem_q[i] <= 32'ha5000000 | 32'(i);
      end
    end else if (mem_ack && mem_req && mem_we) begin
      mem_q[mem_addr[11:2]] <= mem_wdata;
    end
  end
endmodule

/* File: block_transfer_sequencer_test.sv */
`timescale 1ns/1ns
module block_transfer_sequencer_test;
  ////////////////////////////////////////////////////////////
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, wait_cyc;
  logic [31:0] pwdata, prdata, rf_rd_data, rf_wr_data, abort_addr;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, rq, lo, fin;
  logic        rf_rd_user, rf_we, rf_wr_user, status_restore, re;
  logic        mem_req, mem_we, mem_ack, mem_abort;
  logic [3:0]  rf_rd_idx, rf_wr_idx;
  logic [31:0] cur_q [16];                // Current bank
  logic [31:0] usr_q [16];                // User bank
  logic [31:0] a_log[$], d_log[$], w_log[$]; // Transfer and write logs
  int          n_mismatch, comparisons, m, i;

  bts_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rf_rd_idx(rf_rd_idx), .rf_rd_user(rf_rd_user),
    .rf_rd_data(rf_rd_data), .rf_we(rf_we), .rf_wr_idx(rf_wr_idx),
    .rf_wr_user(rf_wr_user), .rf_wr_data(rf_wr_data), .status_restore(status_restore),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_abort(mem_abort));
  bts_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .mem_abort(mem_abort), .wait_cyc(wait_cyc),
    .abort_addr(abort_addr));

  // Register file answers in the same cycle
  assign rf_rd_data = rf_rd_user ? usr_q[rf_rd_idx] : cur_q[rf_rd_idx];

  // Log accepted transfers and register writes with their flags
  always @(posedge pclk) begin
    if (mem_req && mem_ack) begin
      a_log.push_back(mem_addr);
      d_log.push_back(mem_wdata);
    end
    if (rf_we) begin
      w_log.push_back({26'h0, status_restore, rf_wr_user, rf_wr_idx});
      if (rf_wr_user) usr_q[rf_wr_idx] <= rf_wr_data;
      else cur_q[rf_wr_idx] <= rf_wr_data;
    end
  end

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] mk(input logic [3:0] c, input logic [4:0] f,
                                     input logic [3:0] b, input logic [15:0] l);
    return {c, 3'b100, f, b, l};
  endfunction

  task automatic end_sim;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the answer is taken at the pready edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      n_mismatch++;
      end_sim();
    end
  endtask

  // Load an instruction, start it, poll until idle; rq holds status
  task automatic run(input logic [31:0] ins, input logic [31:0] pc, input logic [3:0] fl);
    int k;
    a_log.delete();
    d_log.delete();
    w_log.delete();
    apb(bts_pkg::ADDR_INSTR, 1'b1, ins);
    apb(bts_pkg::ADDR_PC, 1'b1, pc);
    apb(bts_pkg::ADDR_FLAGS, 1'b1, {28'h0, fl});
    apb(bts_pkg::ADDR_CTRL, 1'b1, 32'h00000001);
    for (k = 0; k < 100; k++) begin
      apb(bts_pkg::ADDR_CTRL, 1'b0, 32'h0);
      if (rq[bts_pkg::STAT_BUSY] === 1'b0) break;
    end
    if (k == 100) begin
      n_mismatch++;
      end_sim();
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {n_mismatch, comparisons, wait_cyc} = '0;
    abort_addr = 32'hffffffff;
    for (i = 0; i < 16; i++) begin
      cur_q[i] = 32'h0;
      usr_q[i] = 32'h0;
    end
    usr_q[2] = 32'h22222222;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Every stacking mode, base lowest in list, growing latency
    for (m = 0; m < 4; m++) begin
      cur_q[1] = 32'h00001000;
      cur_q[5] = 32'h55555555;
      cur_q[7] = 32'h77777777;
      wait_cyc <= 8'(m);
      run(mk(4'he, {m[1], m[0], 3'b010}, 4'h1, 16'h00a2), 32'h0, 4'h0);
      lo  = m[0] ? (m[1] ? 32'h1004 : 32'h1000) : (m[1] ? 32'h0ff4 : 32'h0ff8);
      fin = m[0] ? 32'h100c : 32'h0ff4;
      chk(32'(a_log.size()), 32'h3);
      for (i = 0; i < 3; i++) chk(a_log[i], lo + 32'(4 * i));
      chk(d_log[0], 32'h00001000);
      chk(d_log[1], 32'h55555555);
      chk(d_log[2], 32'h77777777);
      chk(cur_q[1], fin);
      apb(bts_pkg::ADDR_RESULT, 1'b0, 32'h0);
      chk(rq, fin);
      $display("test mode %0d done", m);
    end
    // Unaligned base, stored pc, no write-back
    cur_q[2] = 32'h20202020;
    cur_q[3] = 32'h00002002;
    wait_cyc <= 8'h02;
    run(mk(4'he, 5'b01000, 4'h3, 16'h8004), 32'h00000203, 4'h0);
    chk(a_log[0], 32'h00002002);
    chk(a_log[1], 32'h00002006);
    chk(d_log[0], 32'h20202020);
    chk(d_log[1], 32'h00000208);
    chk(cur_q[3], 32'h00002002);
    $display("test store pc done");
    // Load with base in list, no write-back, pc low bits dropped
    cur_q[4] = 32'h00003100;
    wait_cyc <= 8'h00;
    run(mk(4'he, 5'b11001, 4'h4, 16'h8050), 32'h0, 4'h0);
    chk(cur_q[4], 32'ha5000041);
    chk(cur_q[6], 32'ha5000042);
    chk(cur_q[15], 32'ha5000040);
    chk(w_log[0], 32'h04);
    chk(w_log[1], 32'h06);
    chk(w_log[2], 32'h0f);
    $display("test load done");
    // Special loads; no write-back, as software must
    cur_q[5] = 32'h00003200;
    run(mk(4'he, 5'b01101, 4'h5, 16'h8004), 32'h0, 4'h0);
    chk(w_log[0], 32'h02);
    chk(w_log[1], 32'h2f);
    chk(cur_q[15], 32'ha5000080);
    run(mk(4'he, 5'b01101, 4'h5, 16'h0002), 32'h0, 4'h0);
    chk(w_log[0], 32'h11);
    chk(usr_q[1], 32'ha5000080);
    // Store with special bit reads both registers from the user bank
    cur_q[1] = 32'h11110000;
    cur_q[10] = 32'h00005000;
    run(mk(4'he, 5'b01100, 4'ha, 16'h0006), 32'h0, 4'h0);
    chk(d_log[0], 32'ha5000080);
    chk(d_log[1], 32'h22222222);
    $display("test user bank done");
    // Abort on the second word of a write-back store
    cur_q[8] = 32'h00004000;
    abort_addr <= 32'h00004004;
    wait_cyc <= 8'h01;
    run(mk(4'he, 5'b01010, 4'h8, 16'h000f), 32'h0, 4'h0);
    chk(32'(a_log.size()), 32'h1);
    chk(cur_q[8], 32'h00004000);
    chk(w_log[0], 32'h08);
    chk({30'h0, rq[bts_pkg::STAT_ABRT], rq[bts_pkg::STAT_DONE]}, 32'h3);
    abort_addr <= 32'hffffffff;
    $display("test abort done");
    // Equal condition with zero flag clear, then set
    cur_q[9] = 32'h00001000;
    for (m = 0; m < 2; m++) begin
      run(mk(4'h0, 5'b01000, 4'h9, 16'h0001), 32'h0, m[0] ? 4'h4 : 4'h0);
      chk(32'(a_log.size()), 32'(m));
      chk({31'h0, rq[bts_pkg::STAT_SKIP]}, 32'(1 - m));
    end
    $display("test condition done");
    // Unmapped address answers with an error and zero data
    apb(8'h14, 1'b0, 32'h0);
    chk({31'h0, re}, 32'h1);
    chk(rq, 32'h0);
    $display("test unmapped done");
    end_sim();
  end
endmodule
